/* File: inc/bcd_pkg.sv */
// Package of constants and types for the bus cycle status decoder
`default_nettype none
package bcd_pkg;
   // Status vector bit positions
   localparam int BCD_BIT_GRANT = 0;
   localparam int BCD_BIT_DIR = 1;
   localparam int BCD_BIT_SIZE_LO = 2;
   localparam int BCD_BIT_FC_LO = 4;
   localparam int BCD_BIT_SIZE_ACK_LO = 7;
   localparam int BCD_BIT_SYNC_TERM = 9;
   localparam int BCD_BIT_BUS_ERR = 10;
   localparam int BCD_BIT_HALT = 11;
   localparam int BCD_BIT_BURST_REQ = 12;
   localparam int BCD_BIT_BURST_ACK = 13;
   localparam int BCD_BIT_INHIBIT = 14;
   localparam int BCD_BIT_REFILL = 15;
   localparam int BCD_VEC_W = 16;

   // Register map, word index on the 3-bit address port
   localparam logic [2:0] BCD_ADDR_CTRL = 3'h0;
   localparam logic [2:0] BCD_ADDR_IRQ_STAT = 3'h1;
   localparam logic [2:0] BCD_ADDR_IRQ_MASK = 3'h2;
   localparam logic [2:0] BCD_ADDR_VECTOR = 3'h3;
   localparam logic [2:0] BCD_ADDR_CLASS = 3'h4;
   localparam logic [2:0] BCD_ADDR_COUNT = 3'h5;

   // Reset values
   localparam logic [31:0] BCD_RST_CTRL = 32'h0000_0001;
   localparam logic [4:0] BCD_RST_MASK = 5'h00;
   localparam int BCD_IRQ_W = 5;

   // Interrupt event bit positions
   localparam int BCD_EV_CAPTURE = 0;
   localparam int BCD_EV_BUS_ERR = 1;
   localparam int BCD_EV_HALT = 2;
   localparam int BCD_EV_RETRY = 3;
   localparam int BCD_EV_OVERRUN = 4;

   // Beats of a burst taken on the second strobe
   localparam int BCD_BURST_BEATS = 3;

   // Size codes
   localparam logic [1:0] BCD_SIZE_LONG = 2'b00;
   localparam logic [1:0] BCD_SIZE_BYTE = 2'b01;
   localparam logic [1:0] BCD_SIZE_WORD = 2'b10;
   localparam logic [1:0] BCD_SIZE_3BYTE = 2'b11;

   // Termination patterns: burst on bits 14..7, the others on bits 11..7 or 11..10
   localparam logic [7:0] BCD_PAT_BURST = 8'h9B;
   localparam logic [4:0] BCD_PAT_SYNC = 5'h1B;
   localparam logic [4:0] BCD_PAT_ASYNC32 = 5'h1C;
   localparam logic [4:0] BCD_PAT_ASYNC16 = 5'h1D;
   localparam logic [4:0] BCD_PAT_ASYNC8 = 5'h1E;
   localparam logic [1:0] BCD_PAT_BUS_ERR = 2'b10;
   localparam logic [1:0] BCD_PAT_HALT = 2'b01;
   localparam logic [1:0] BCD_PAT_RETRY = 2'b00;

   // Upper three bits of the requested-and-acknowledged code
   localparam logic [2:0] BCD_ACK_NONE = 3'b000;
   localparam logic [2:0] BCD_ACK_SYNC = 3'b011;
   localparam logic [2:0] BCD_ACK_DS32 = 3'b100;
   localparam logic [2:0] BCD_ACK_DS16 = 3'b101;
   localparam logic [2:0] BCD_ACK_DS8 = 3'b110;

   // Function codes
   localparam logic [2:0] BCD_FC_USER_DATA = 3'b001;
   localparam logic [2:0] BCD_FC_USER_PROG = 3'b010;
   localparam logic [2:0] BCD_FC_SUPR_DATA = 3'b101;
   localparam logic [2:0] BCD_FC_SUPR_PROG = 3'b110;
   localparam logic [2:0] BCD_FC_CPU_SPACE = 3'b111;

   typedef enum logic [3:0] {
      BCD_CYC_UNKNOWN = 4'b0000,
      BCD_CYC_GRANT = 4'b0001,
      BCD_CYC_USER_DATA_WR = 4'b0010,
      BCD_CYC_USER_DATA_RD = 4'b0011,
      BCD_CYC_USER_PROG_RD = 4'b0100,
      BCD_CYC_SUPR_DATA_WR = 4'b0101,
      BCD_CYC_SUPR_DATA_RD = 4'b0110,
      BCD_CYC_SUPR_PROG_RD = 4'b0111,
      BCD_CYC_CPU_SPACE = 4'b1000
   } bcd_cycle_e;

   typedef enum logic [3:0] {
      BCD_TERM_NONE = 4'b0000,
      BCD_TERM_BURST = 4'b0001,
      BCD_TERM_SYNC = 4'b0010,
      BCD_TERM_ASYNC32 = 4'b0011,
      BCD_TERM_ASYNC16 = 4'b0100,
      BCD_TERM_ASYNC8 = 4'b0101,
      BCD_TERM_BUS_ERR = 4'b0110,
      BCD_TERM_HALT = 4'b0111,
      BCD_TERM_RETRY = 4'b1000
   } bcd_term_e;

   // Sampled bus status, bit 15 first
   typedef struct packed {
      logic refill_line;
      logic cache_inhibit_line;
      logic cache_burst_acknowledge_line;
      logic cache_burst_request_line;
      logic halt_line;
      logic bus_error_line;
      logic synchronous_termination_line;
      logic [1:0] size_acknowledge_field;
      logic [2:0] function_code_field;
      logic [1:0] requested_size_field;
      logic direction_line;
      logic grant_acknowledge_line;
   } bcd_status_s;

   // Decoded result of one captured state
   typedef struct packed {
      logic from_burst_strobe;
      bcd_cycle_e cycle;
      bcd_term_e term;
      logic is_read;
      logic is_write;
      logic [1:0] requested_size;
      logic [4:0] requested_acknowledged_code;
   } bcd_class_s;
endpackage
`default_nettype wire

/* File: rtl/bcd_decoder.sv */
// Bus cycle status decoder: capture, classification, registers and interrupt
// Behaviour
// (R01) Bit 0 grant line; low means grant cycle
// (R02) Bit 1 direction; high read, low write
// (R03) Bits 3:2 requested size code
// (R04) Bits 6:4 function code decoding cycle space
// (R05) Low bits 11 read, 01 write
// (R06) Bits 8:7 size acknowledge lines
// (R07) Bit 9 synchronous termination line
// (R08) Bit 10 bus error line
// (R09) Bit 11 halt line
// (R10) Bit 12 cache burst request line
// (R11) Bit 13 cache burst acknowledge line
// (R12) Bit 14 cache inhibit line
// (R13) Bit 15 pipeline refill indication
// (R14) Classify termination from bits 14..7
// (R15) Five-bit requested and acknowledged code
// (R16) Capture on address strobe rising edge
// (R17) First three burst beats on second strobe
// (R18) Classes registered with the captured state
`default_nettype none
module bcd_decoder #(
   parameter int BURST_BEATS = bcd_pkg::BCD_BURST_BEATS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Observed bus lines, synchronous to sys_clk
   input wire logic grant_acknowledge_line,
   input wire logic direction_line,
   input wire logic [1:0] requested_size_field,
   input wire logic [2:0] function_code_field,
   input wire logic [1:0] size_acknowledge_field,
   input wire logic synchronous_termination_line,
   input wire logic bus_error_line,
   input wire logic halt_line,
   input wire logic cache_burst_request_line,
   input wire logic cache_burst_acknowledge_line,
   input wire logic cache_inhibit_line,
   input wire logic refill_line,
   input wire logic address_strobe_line,
   input wire logic burst_strobe_line,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Capture results
   output logic capture_valid,
   output bcd_pkg::bcd_status_s capture_vector,
   output bcd_pkg::bcd_class_s capture_class,
   output logic irq
);
   import bcd_pkg::*;

   // Refused at elaboration: the beat counter is only two bits wide
   if (BURST_BEATS < 1 || BURST_BEATS > BCD_BURST_BEATS) begin : g_bad_beats
      $error("BURST_BEATS must be 1 to 3");
   end

   bcd_status_s live_vec;
   bcd_class_s live_class;
   logic as_rise;
   logic bs_rise;
   logic take_as;
   logic take_bs;

   logic as_prev_reg, as_prev_next;
   logic bs_prev_reg, bs_prev_next;
   logic [1:0] beat_reg, beat_next;
   logic valid_reg, valid_next;
   bcd_status_s vec_reg, vec_next;
   bcd_class_s class_reg, class_next;
   logic enable_reg, enable_next;
   logic [BCD_IRQ_W-1:0] stat_reg, stat_next;
   logic [BCD_IRQ_W-1:0] mask_reg, mask_next;
   logic [15:0] count_reg, count_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [BCD_IRQ_W-1:0] events;
   logic [BCD_IRQ_W-1:0] clear_bits;

   // Pack the bus lines into the status vector
   always_comb begin
      live_vec.grant_acknowledge_line = grant_acknowledge_line; // R01
      live_vec.direction_line = direction_line; // R02
      live_vec.requested_size_field = requested_size_field; // R03
      live_vec.function_code_field = function_code_field; // R04
      live_vec.size_acknowledge_field = size_acknowledge_field; // R06
      live_vec.synchronous_termination_line = synchronous_termination_line; // R07
      live_vec.bus_error_line = bus_error_line; // R08
      live_vec.halt_line = halt_line; // R09
      live_vec.cache_burst_request_line = cache_burst_request_line; // R10
      live_vec.cache_burst_acknowledge_line = cache_burst_acknowledge_line; // R11
      live_vec.cache_inhibit_line = cache_inhibit_line; // R12
      live_vec.refill_line = refill_line; // R13
   end

   // Classification of the live vector
   always_comb begin
      logic [15:0] raw;
      logic [7:0] term_bits;
      logic [1:0] low_bits;
      raw = live_vec;
      term_bits = raw[BCD_BIT_INHIBIT:BCD_BIT_SIZE_ACK_LO];
      low_bits = raw[BCD_BIT_DIR:BCD_BIT_GRANT];
      live_class.from_burst_strobe = 1'b0;
      live_class.requested_size = raw[BCD_BIT_SIZE_LO+1:BCD_BIT_SIZE_LO]; // R03
      live_class.is_read = (low_bits == 2'b11); // R05
      live_class.is_write = (low_bits == 2'b01); // R05
      live_class.cycle = BCD_CYC_UNKNOWN;
      if (!raw[BCD_BIT_GRANT]) begin
         live_class.cycle = BCD_CYC_GRANT; // R01
      end else begin
         case (raw[BCD_BIT_FC_LO+2:BCD_BIT_FC_LO]) // R04
            BCD_FC_USER_DATA: begin
               live_class.cycle = raw[BCD_BIT_DIR] ? BCD_CYC_USER_DATA_RD
                                                   : BCD_CYC_USER_DATA_WR; // R05
            end
            BCD_FC_USER_PROG: begin
               if (raw[BCD_BIT_DIR]) begin
                  live_class.cycle = BCD_CYC_USER_PROG_RD; // R05
               end
            end
            BCD_FC_SUPR_DATA: begin
               live_class.cycle = raw[BCD_BIT_DIR] ? BCD_CYC_SUPR_DATA_RD
                                                   : BCD_CYC_SUPR_DATA_WR; // R05
            end
            BCD_FC_SUPR_PROG: begin
               if (raw[BCD_BIT_DIR]) begin
                  live_class.cycle = BCD_CYC_SUPR_PROG_RD; // R05
               end
            end
            BCD_FC_CPU_SPACE: begin
               live_class.cycle = BCD_CYC_CPU_SPACE; // R04
            end
            default: begin
               live_class.cycle = BCD_CYC_UNKNOWN;
            end
         endcase
      end
      // Burst is tested first since its pattern is a case of the sync one
      live_class.term = BCD_TERM_NONE;
      if (term_bits == BCD_PAT_BURST) begin
         live_class.term = BCD_TERM_BURST; // R14
      end else if (term_bits[4:0] == BCD_PAT_SYNC) begin
         live_class.term = BCD_TERM_SYNC; // R14
      end else if (term_bits[4:0] == BCD_PAT_ASYNC32) begin
         live_class.term = BCD_TERM_ASYNC32; // R14
      end else if (term_bits[4:0] == BCD_PAT_ASYNC16) begin
         live_class.term = BCD_TERM_ASYNC16; // R14
      end else if (term_bits[4:0] == BCD_PAT_ASYNC8) begin
         live_class.term = BCD_TERM_ASYNC8; // R14
      end else if (term_bits[4:3] == BCD_PAT_BUS_ERR) begin
         live_class.term = BCD_TERM_BUS_ERR; // R14
      end else if (term_bits[4:3] == BCD_PAT_HALT) begin
         live_class.term = BCD_TERM_HALT; // R14
      end else if (term_bits[4:3] == BCD_PAT_RETRY) begin
         live_class.term = BCD_TERM_RETRY; // R14
      end
      case (live_class.term) // R15
         BCD_TERM_BURST, BCD_TERM_SYNC: begin
            live_class.requested_acknowledged_code = {BCD_ACK_SYNC,
                                                      live_class.requested_size};
         end
         BCD_TERM_ASYNC32: begin
            live_class.requested_acknowledged_code = {BCD_ACK_DS32,
                                                      live_class.requested_size};
         end
         BCD_TERM_ASYNC16: begin
            live_class.requested_acknowledged_code = {BCD_ACK_DS16,
                                                      live_class.requested_size};
         end
         BCD_TERM_ASYNC8: begin
            live_class.requested_acknowledged_code = {BCD_ACK_DS8,
                                                      live_class.requested_size};
         end
         default: begin
            live_class.requested_acknowledged_code = {BCD_ACK_NONE,
                                                      live_class.requested_size};
         end
      endcase
   end

   // Strobe edges; inputs are already synchronous so one stage suffices
   assign as_rise = address_strobe_line && !as_prev_reg;
   assign bs_rise = burst_strobe_line && !bs_prev_reg;
   assign take_as = enable_reg && as_rise; // R16
   // A burst edge with an address edge belongs to the address capture and is not taken twice
   assign take_bs = enable_reg && bs_rise && !as_rise
                    && (beat_reg < 2'(BURST_BEATS)); // R17

   // Capture path
   always_comb begin
      as_prev_next = address_strobe_line;
      bs_prev_next = burst_strobe_line;
      valid_next = 1'b0;
      vec_next = vec_reg;
      class_next = class_reg;
      beat_next = beat_reg;
      if (take_as) begin
         valid_next = 1'b1;
         vec_next = live_vec; // R16
         class_next = live_class; // R18
         beat_next = 2'd0;
      end else if (take_bs) begin
         valid_next = 1'b1;
         vec_next = live_vec; // R17
         class_next = live_class; // R18
         class_next.from_burst_strobe = 1'b1;
         beat_next = beat_reg + 2'd1;
      end
   end

   // Interrupt events and register port
   always_comb begin
      events = '0;
      events[BCD_EV_CAPTURE] = valid_next;
      events[BCD_EV_BUS_ERR] = valid_next && (class_next.term == BCD_TERM_BUS_ERR);
      events[BCD_EV_HALT] = valid_next && (class_next.term == BCD_TERM_HALT);
      events[BCD_EV_RETRY] = valid_next && (class_next.term == BCD_TERM_RETRY);
      events[BCD_EV_OVERRUN] = enable_reg && bs_rise && !as_rise && !take_bs;
      clear_bits = '0;
      enable_next = enable_reg;
      mask_next = mask_reg;
      count_next = count_reg;
      if (valid_next) begin
         count_next = count_reg + 16'd1;
      end
      if (reg_wr) begin
         if (reg_addr == BCD_ADDR_CTRL) begin
            enable_next = reg_wdata[0];
         end else if (reg_addr == BCD_ADDR_IRQ_STAT) begin
            clear_bits = reg_wdata[BCD_IRQ_W-1:0];
         end else if (reg_addr == BCD_ADDR_IRQ_MASK) begin
            mask_next = reg_wdata[BCD_IRQ_W-1:0];
         end else if (reg_addr == BCD_ADDR_COUNT) begin
            count_next = 16'd0;
         end
      end
      // A new event wins over a clear in the same cycle
      stat_next = (stat_reg & ~clear_bits) | events;
      irq_next = |(stat_next & mask_next);
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         if (reg_addr == BCD_ADDR_CTRL) begin
            rdata_next = {31'd0, enable_reg};
         end else if (reg_addr == BCD_ADDR_IRQ_STAT) begin
            rdata_next = {{(32-BCD_IRQ_W){1'b0}}, stat_reg};
         end else if (reg_addr == BCD_ADDR_IRQ_MASK) begin
            rdata_next = {{(32-BCD_IRQ_W){1'b0}}, mask_reg};
         end else if (reg_addr == BCD_ADDR_VECTOR) begin
            rdata_next = {16'd0, vec_reg};
         end else if (reg_addr == BCD_ADDR_CLASS) begin
            rdata_next = {14'd0, class_reg};
         end else if (reg_addr == BCD_ADDR_COUNT) begin
            rdata_next = {16'd0, count_reg};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         as_prev_reg <= 1'b0;
         bs_prev_reg <= 1'b0;
         beat_reg <= 2'd0;
         valid_reg <= 1'b0;
         vec_reg <= '0;
         class_reg <= '0;
         enable_reg <= BCD_RST_CTRL[0];
         stat_reg <= '0;
         mask_reg <= BCD_RST_MASK;
         count_reg <= 16'd0;
         rdata_reg <= 32'h0000_0000;
         irq_reg <= 1'b0;
      end else begin
         as_prev_reg <= as_prev_next;
         bs_prev_reg <= bs_prev_next;
         beat_reg <= beat_next;
         valid_reg <= valid_next;
         vec_reg <= vec_next;
         class_reg <= class_next;
         enable_reg <= enable_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         count_reg <= count_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign capture_valid = valid_reg;
   assign capture_vector = vec_reg;
   assign capture_class = class_reg;
   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;
endmodule // bcd_decoder
`default_nettype wire

/* File: tb/bcd_decoder_sva.sv */
// Port assertions for the bus cycle status decoder
`default_nettype none
module bcd_decoder_sva #(
   parameter int BURST_BEATS = 3
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic grant_acknowledge_line,
   input wire logic direction_line,
   input wire logic [1:0] requested_size_field,
   input wire logic [2:0] function_code_field,
   input wire logic [1:0] size_acknowledge_field,
   input wire logic synchronous_termination_line,
   input wire logic bus_error_line,
   input wire logic halt_line,
   input wire logic cache_burst_request_line,
   input wire logic cache_burst_acknowledge_line,
   input wire logic cache_inhibit_line,
   input wire logic refill_line,
   input wire logic address_strobe_line,
   input wire logic burst_strobe_line,
   input wire logic [2:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic capture_valid,
   input wire bcd_pkg::bcd_status_s capture_vector,
   input wire bcd_pkg::bcd_class_s capture_class,
   input wire logic irq
);
   import bcd_pkg::*;
   logic as_prev_reg, bs_prev_reg, en_reg, as_rise, bs_rise;
   logic [1:0] beat_reg;
   logic [15:0] lines;
   // Edge history restarts at 0, so a strobe high at release is a rise
   assign as_rise = address_strobe_line && !as_prev_reg && en_reg;
   assign bs_rise = burst_strobe_line && !bs_prev_reg && en_reg && !as_rise;
   assign lines = {refill_line, cache_inhibit_line, cache_burst_acknowledge_line,
      cache_burst_request_line, halt_line, bus_error_line, synchronous_termination_line,
      size_acknowledge_field, function_code_field, requested_size_field, direction_line,
      grant_acknowledge_line};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         as_prev_reg <= 1'b0;
         bs_prev_reg <= 1'b0;
         en_reg <= 1'b1;
         beat_reg <= 2'h0;
      end else begin
         as_prev_reg <= address_strobe_line;
         bs_prev_reg <= burst_strobe_line;
         if (reg_wr && reg_addr == BCD_ADDR_CTRL) en_reg <= reg_wdata[0];
         if (as_rise) beat_reg <= 2'h0;
         else if (bs_rise && beat_reg < BURST_BEATS) beat_reg <= beat_reg + 2'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence as_cap_s;
      as_rise;
   endsequence
   sequence bs_cap_s;
      bs_rise && beat_reg < BURST_BEATS;
   endsequence
   a_as_capture: assert property (as_cap_s |=> capture_valid &&
      capture_vector == $past(lines) && !capture_class.from_burst_strobe)
      else $error("address strobe capture wrong");
   a_beat_capture: assert property (bs_cap_s |=> capture_valid &&
      capture_vector == $past(lines) && capture_class.from_burst_strobe)
      else $error("burst beat capture wrong");
   a_beat_refused: assert property (bs_rise && beat_reg >= BURST_BEATS |=> !capture_valid)
      else $error("extra burst beat captured");
   a_no_spurious: assert property (!as_rise && !bs_rise |=> !capture_valid)
      else $error("capture without strobe");
   a_grant_cycle: assert property (capture_valid && !capture_vector[0] |->
      capture_class.cycle == BCD_CYC_GRANT) else $error("grant cycle not decoded");
   a_read_write: assert property (capture_valid |->
      capture_class.is_read == (capture_vector[1:0] == 2'b11) &&
      capture_class.is_write == (capture_vector[1:0] == 2'b01)) else $error("direction wrong");
   a_size_code: assert property (capture_valid |->
      capture_class.requested_size == capture_vector[3:2] &&
      capture_class.requested_acknowledged_code[1:0] == capture_vector[3:2])
      else $error("size code wrong");
   a_burst_term: assert property (capture_valid && capture_vector[14:7] == 8'h9B |->
      capture_class.term == BCD_TERM_BURST &&
      capture_class.requested_acknowledged_code[4:2] == 3'b011) else $error("burst term wrong");
   a_async_term: assert property (capture_valid && capture_vector[11:7] == 5'h1E |->
      capture_class.term == BCD_TERM_ASYNC8 &&
      capture_class.requested_acknowledged_code[4:2] == 3'b110) else $error("8-bit term wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read");
endmodule // bcd_decoder_sva
bind bcd_decoder bcd_decoder_sva #(.BURST_BEATS(BURST_BEATS)) i_sva (.*);
`default_nettype wire

/* File: tb/bcd_bus_model.sv */
// Model of the observed processor bus
`default_nettype none
module bcd_bus_model (
   // Bench side
   input wire bcd_pkg::bcd_status_s vec,
   input wire logic as_req,
   input wire logic bs_req,
   // Observed lines
   output bcd_pkg::bcd_status_s lines,
   output logic as_line,
   output logic bs_line
);
   import bcd_pkg::*;
   // Status is valid only under a strobe; otherwise stale data must not match
   assign lines = (as_req || bs_req) ? vec : bcd_status_s'(~vec);
   assign as_line = as_req;
   assign bs_line = bs_req;
endmodule // bcd_bus_model
`default_nettype wire

/* File: tb/bcd_decoder_bench.sv */
// Self-checking bench for the bus cycle status decoder
`default_nettype none
module bcd_decoder_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import bcd_pkg::*;
   logic sys_clk, srst, as_req, bs_req, as_line, bs_line, reg_wr, reg_rd;
   logic capture_valid, irq;
   logic [2:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [15:0] v;
   bcd_status_s vec, lines, capture_vector;
   bcd_class_s capture_class;
   int err_count, n_tests, cyc;
   logic [7:0] pat [8] = '{8'h9B, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h10, 8'h08, 8'h00};
   logic [7:0] msk [8] = '{8'h00, 8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'hE7, 8'hE7, 8'hE7};
   bcd_bus_model i_bus (.vec(vec), .as_req(as_req), .bs_req(bs_req), .lines(lines),
      .as_line(as_line), .bs_line(bs_line));
   bcd_decoder #(.BURST_BEATS(BCD_BURST_BEATS)) i_dut (.sys_clk(sys_clk), .srst(srst),
      .grant_acknowledge_line(lines.grant_acknowledge_line),
      .direction_line(lines.direction_line), .requested_size_field(lines.requested_size_field),
      .function_code_field(lines.function_code_field),
      .size_acknowledge_field(lines.size_acknowledge_field),
      .synchronous_termination_line(lines.synchronous_termination_line),
      .bus_error_line(lines.bus_error_line), .halt_line(lines.halt_line),
      .cache_burst_request_line(lines.cache_burst_request_line),
      .cache_burst_acknowledge_line(lines.cache_burst_acknowledge_line),
      .cache_inhibit_line(lines.cache_inhibit_line), .refill_line(lines.refill_line),
      .address_strobe_line(as_line), .burst_strobe_line(bs_line), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .capture_valid(capture_valid), .capture_vector(capture_vector),
      .capture_class(capture_class), .irq(irq));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic end_sim();
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_sim();
      end
   end
   function automatic bcd_class_s exp_class(input logic [15:0] s, input logic fb);
      bcd_class_s c;
      logic [7:0] t;
      logic [2:0] up;
      c = '0;
      t = s[14:7];
      up = 3'b000;
      c.from_burst_strobe = fb;
      c.is_read = s[1:0] == 2'b11;
      c.is_write = s[1:0] == 2'b01;
      c.requested_size = s[3:2];
      if (!s[0]) c.cycle = BCD_CYC_GRANT;
      else case (s[6:4])
         3'b001: c.cycle = c.is_read ? BCD_CYC_USER_DATA_RD : BCD_CYC_USER_DATA_WR;
         3'b010: c.cycle = c.is_read ? BCD_CYC_USER_PROG_RD : BCD_CYC_UNKNOWN;
         3'b101: c.cycle = c.is_read ? BCD_CYC_SUPR_DATA_RD : BCD_CYC_SUPR_DATA_WR;
         3'b110: c.cycle = c.is_read ? BCD_CYC_SUPR_PROG_RD : BCD_CYC_UNKNOWN;
         3'b111: c.cycle = BCD_CYC_CPU_SPACE;
         default: c.cycle = BCD_CYC_UNKNOWN;
      endcase
      if (t == 8'h9B) c.term = BCD_TERM_BURST;
      else if (t[4:0] == 5'h1B) c.term = BCD_TERM_SYNC;
      else if (t[4:0] == 5'h1C) c.term = BCD_TERM_ASYNC32;
      else if (t[4:0] == 5'h1D) c.term = BCD_TERM_ASYNC16;
      else if (t[4:0] == 5'h1E) c.term = BCD_TERM_ASYNC8;
      else if (t[4:3] == 2'b10) c.term = BCD_TERM_BUS_ERR;
      else if (t[4:3] == 2'b01) c.term = BCD_TERM_HALT;
      else if (t[4:3] == 2'b00) c.term = BCD_TERM_RETRY;
      case (c.term)
         BCD_TERM_BURST, BCD_TERM_SYNC: up = 3'b011;
         BCD_TERM_ASYNC32: up = 3'b100;
         BCD_TERM_ASYNC16: up = 3'b101;
         BCD_TERM_ASYNC8: up = 3'b110;
         default: up = 3'b000;
      endcase
      c.requested_acknowledged_code = {up, s[3:2]};
      return c;
   endfunction
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cap(input logic [15:0] s, input logic fb);
      bcd_class_s e;
      e = exp_class(s, fb);
      n_tests++;
      if (capture_valid !== 1'b1 || capture_vector !== s || capture_class !== e) begin
         err_count++;
         $display("mismatch %0t capture %h class %h expected %h", $time, capture_vector,
            capture_class, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] w);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [31:0] q);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // A refused strobe must leave capture_valid low
   task automatic cap(input logic [15:0] s, input logic burst, input logic ok);
      @(posedge sys_clk);
      vec <= s;
      if (burst) bs_req <= 1'b1;
      else as_req <= 1'b1;
      @(posedge sys_clk);
      as_req <= 1'b0;
      bs_req <= 1'b0;
      #1;
      if (ok) chk_cap(s, burst);
      else chk_reg({31'h0, capture_valid}, 32'h0);
   endtask
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge sys_clk);
      #1 chk_reg({31'h0, irq}, {31'h0, e});
   endtask
   initial begin
      {srst, as_req, bs_req, reg_wr, reg_rd, reg_addr, reg_wdata, vec} = '0;
      srst = 1'b1;
      d = $urandom(32'h2b4e);
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      rd(BCD_ADDR_CTRL, d);
      chk_reg(d, BCD_RST_CTRL);
      rd(BCD_ADDR_IRQ_MASK, d);
      chk_reg(d, 32'h0000_0000);
      rd(3'h7, d);
      chk_reg(d, 32'h0000_0000);
      for (int i = 0; i < 64; i++) begin
         v = 16'($urandom);
         v[6:4] = 3'(i);
         v[14:7] = (pat[i / 8] & ~msk[i / 8]) | (v[14:7] & msk[i / 8]);
         cap(v, 1'b0, 1'b1);
      end
      wr(BCD_ADDR_IRQ_STAT, 32'h0000_001F);
      cap(16'($urandom), 1'b0, 1'b1);
      for (int b = 0; b <= BCD_BURST_BEATS; b++) cap(16'($urandom), 1'b1, b < BCD_BURST_BEATS);
      rd(BCD_ADDR_IRQ_STAT, d);
      chk_reg(d & 32'h0000_0010, 32'h0000_0010);
      wr(BCD_ADDR_CTRL, 32'h0000_0000);
      cap(16'h0801, 1'b0, 1'b0);
      wr(BCD_ADDR_CTRL, 32'h0000_0001);
      wr(BCD_ADDR_COUNT, 32'h0000_0000);
      repeat (3) cap(16'($urandom), 1'b0, 1'b1);
      rd(BCD_ADDR_COUNT, d);
      chk_reg(d, 32'h0000_0003);
      wr(BCD_ADDR_IRQ_STAT, 32'h0000_001F);
      cap(16'h0801, 1'b0, 1'b1);
      rd(BCD_ADDR_IRQ_STAT, d);
      chk_reg(d, 32'h0000_0003);
      chk_irq(1'b0);
      wr(BCD_ADDR_IRQ_MASK, 32'h0000_0002);
      chk_irq(1'b1);
      wr(BCD_ADDR_IRQ_STAT, 32'h0000_0002);
      chk_irq(1'b0);
      rd(BCD_ADDR_VECTOR, d);
      chk_reg(d, 32'h0000_0801);
      rd(BCD_ADDR_CLASS, d);
      chk_reg(d, {14'h0, exp_class(16'h0801, 1'b0)});
      wr(BCD_ADDR_IRQ_STAT, 32'h0000_001F);
      cap(16'h0401, 1'b0, 1'b1);
      cap(16'h0001, 1'b0, 1'b1);
      rd(BCD_ADDR_IRQ_STAT, d);
      chk_reg(d, 32'h0000_000D);
      end_sim();
   end
endmodule // bcd_decoder_bench
`default_nettype wire
